// File: hdl/ciss_top.v
// Interrupt source selector top: APB registers, routing and core lines.
// Assumes a zero-wait APB master on mclk and events synchronous to mclk.
//
// Summary of operation
// RQ1: Sixteen core lines, zero highest, fifteen lowest.
// RQ2: Lines zero to three fixed, unmaskable, unselectable.
// RQ3: Lines four to fifteen maskable, independently selectable.
// RQ4: Selector fields reset to the default codes.
// RQ5: Six 5-bit fields per selector register.
// RQ6: High register first address, low next.
// RQ7: Codes zero to eleven route core events.
// RQ8: Higher codes route serial, pin, bus, audio.
// RQ9: Pin events are edges of chosen polarity.
// RQ10: Software enables pins as inputs beforehand.
// RQ11: Pin module may drive pin events directly.
// RQ12: Global enable gates maskable lines, saved when taken.
// RQ13: Reserved codes connect the line to nothing.
// RQ14: Bits outside fields read zero, ignore writes.
//
// Implementation choice: the APB slave port.
`include "ciss_map.vh"

module ciss_top (
	mclk,
	sys_rst,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	reset_event,
	nmi_event,
	host_port_event,
	timer0_event,
	timer1_event,
	external_memory_event,
	pin_level,
	pin_enable_field,
	pin_direction_field,
	gpio_pin_event,
	pin_event_0,
	dma_completion_event,
	emulation_event_a,
	emulation_receive_event,
	emulation_transmit_event,
	serial0_transmit_event,
	serial0_receive_event,
	serial1_transmit_event,
	serial1_receive_event,
	i2c_controller0_event,
	i2c_controller1_event,
	audio0_transmit_event,
	audio0_receive_event,
	audio1_transmit_event,
	audio1_receive_event,
	int_taken,
	int_return,
	cpu_int_line,
	global_enable_bit,
	saved_global_enable_bit,
	irq_out
);
	// Clock and synchronous reset.
	input wire mclk;
	input wire sys_rst;
	// APB slave port.
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [31:0] paddr;
	input wire [31:0] pwdata;
	output wire [31:0] prdata;
	output wire pready;
	output wire pslverr;
	// Fixed sources for lines zero and one.
	input wire reset_event;
	input wire nmi_event;
	// Selectable peripheral events.
	input wire host_port_event;
	input wire timer0_event;
	input wire timer1_event;
	input wire external_memory_event;
	// Levels of the four pins behind pin events 4 to 7.
	input wire [3:0] pin_level;
	// Pin enable bits, one per pin, from the pin module.
	input wire [3:0] pin_enable_field;
	// Pin direction bits, one means output.
	input wire [3:0] pin_direction_field;
	// Events made by the pin module itself for pins 4 to 7.
	input wire [3:0] gpio_pin_event;
	// Remaining selectable events, each active high with one code apiece.
	input wire pin_event_0;
	input wire dma_completion_event;
	input wire emulation_event_a;
	input wire emulation_receive_event;
	input wire emulation_transmit_event;
	input wire serial0_transmit_event;
	input wire serial0_receive_event;
	input wire serial1_transmit_event;
	input wire serial1_receive_event;
	input wire i2c_controller0_event;
	input wire i2c_controller1_event;
	input wire audio0_transmit_event;
	input wire audio0_receive_event;
	input wire audio1_transmit_event;
	input wire audio1_receive_event;
	// Core handshakes: an interrupt was taken, or its handler returned.
	input wire int_taken;
	input wire int_return;
	// Lines to the core, bit 0 highest priority.
	output wire [15:0] cpu_int_line;
	// Global enable state as seen by the core.
	output wire global_enable_bit;
	output wire saved_global_enable_bit;
	// Summary interrupt of the sticky status bits.
	output wire irq_out;

	// Selector registers.
	reg [31:0] sel_high_q;
	reg [31:0] sel_low_q;
	// Pin polarity and pin module control bits.
	reg [3:0] polarity_q;
	reg [3:0] gpio_ctrl_q;
	// Global enable and its saved copy; both clear at reset, so no
	// maskable line can reach the core before software opens it.
	reg glob_en_q;
	reg saved_en_q;
	// Sticky status and mask for lines 4 to 15.
	reg [11:0] status_q;
	reg [11:0] mask_q;
	// Read data held for the access phase.
	reg [31:0] prdata_q;
	reg [31:0] rdata_d;
	// Lines presented to the core.
	reg [15:0] line_q;

	// Bus phases.
	wire setup_ph = psel & ~penable;
	wire access_ph = psel & penable;
	wire wr_en = access_ph & pwrite;

	// Address decode; every register is one aligned word.
	wire hit_high = (paddr == `CISS_ADDR_SEL_HIGH); // RQ6
	wire hit_low = (paddr == `CISS_ADDR_SEL_LOW); // RQ6
	wire hit_pin = (paddr == `CISS_ADDR_PIN_CTRL);
	wire hit_glob = (paddr == `CISS_ADDR_GLOBAL);
	wire hit_stat = (paddr == `CISS_ADDR_STATUS);
	wire hit_mask = (paddr == `CISS_ADDR_MASK);
	wire mapped = hit_high | hit_low | hit_pin | hit_glob | hit_stat | hit_mask;

	// Every access finishes in its first access cycle.
	assign pready = 1'b1;
	// An unmapped address is refused with an error and reads as zero.
	// A write to such an address changes no register.
	assign pslverr = access_ph & ~mapped;
	assign prdata = prdata_q;

	// Flattened selector fields, line 4 in the lowest five bits.
	// Bits 15 and 31 of each register belong to no field and are dropped.
	wire [59:0] sel_flat = {
		sel_high_q[`CISS_F5_LSB +: `CISS_FW],
		sel_high_q[`CISS_F4_LSB +: `CISS_FW],
		sel_high_q[`CISS_F3_LSB +: `CISS_FW],
		sel_high_q[`CISS_F2_LSB +: `CISS_FW],
		sel_high_q[`CISS_F1_LSB +: `CISS_FW],
		sel_high_q[`CISS_F0_LSB +: `CISS_FW],
		sel_low_q[`CISS_F5_LSB +: `CISS_FW],
		sel_low_q[`CISS_F4_LSB +: `CISS_FW],
		sel_low_q[`CISS_F3_LSB +: `CISS_FW],
		sel_low_q[`CISS_F2_LSB +: `CISS_FW],
		sel_low_q[`CISS_F1_LSB +: `CISS_FW],
		sel_low_q[`CISS_F0_LSB +: `CISS_FW]}; // RQ5

	// Pin qualification is only a safety net; software is still expected
	// to enable the pins and make them inputs before relying on them.
	wire [3:0] pin_qualify = pin_enable_field & ~pin_direction_field; // RQ10
	wire [3:0] edge_pulse;

	// Edge detection for the four external pins.
	ciss_pin_edge u_edge (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_level(pin_level),
		.polarity(polarity_q),
		.pin_qualify(pin_qualify),
		.edge_pulse(edge_pulse)
	);

	// Each pin either uses the local edge logic or the pin module's event.
	wire [3:0] pin_src = (gpio_ctrl_q & gpio_pin_event) |
		(~gpio_ctrl_q & edge_pulse); // RQ11

	// Event vector indexed by selector code.
	// Reserved codes are tied low here and masked once more in the router.
	wire [31:0] event_vec = {
		audio1_receive_event,
		audio1_transmit_event,
		audio0_receive_event,
		audio0_transmit_event,
		4'h0,
		i2c_controller1_event,
		i2c_controller0_event,
		5'h00,
		pin_event_0,
		serial1_receive_event,
		serial1_transmit_event,
		serial0_receive_event,
		serial0_transmit_event, // RQ8
		emulation_transmit_event,
		emulation_receive_event,
		emulation_event_a,
		dma_completion_event,
		pin_src,
		external_memory_event,
		timer1_event,
		timer0_event,
		host_port_event}; // RQ7

	// Routed level of each programmable line, before global gating.
	wire [11:0] routed;

	ciss_route u_route (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.event_vec(event_vec),
		.sel_flat(sel_flat),
		.line_out(routed)
	);

	// Selector registers take only bits inside the defined fields.
	always @(posedge mclk) begin
		if (sys_rst) begin
			sel_high_q <= `CISS_SEL_HIGH_RESET; // RQ4
			sel_low_q <= `CISS_SEL_LOW_RESET; // RQ4
		end else if (wr_en) begin
			if (hit_high) begin
				sel_high_q <= pwdata & `CISS_SEL_FIELD_MASK; // RQ14
			end
			if (hit_low) begin
				sel_low_q <= pwdata & `CISS_SEL_FIELD_MASK; // RQ14
			end
		end
	end

	// Pin control register: polarity and pin module control.
	always @(posedge mclk) begin
		if (sys_rst) begin
			polarity_q <= 4'h0;
			gpio_ctrl_q <= 4'h0;
		end else if (wr_en & hit_pin) begin
			polarity_q <= pwdata[`CISS_POL_LSB +: 4]; // RQ9
			gpio_ctrl_q <= pwdata[`CISS_GPC_LSB +: 4]; // RQ11
		end
	end

	// Global enable. Taking an interrupt wins over a bus write in the
	// same cycle, because the core must not lose the nesting state.
	always @(posedge mclk) begin
		if (sys_rst) begin
			glob_en_q <= 1'b0; // RQ12
			saved_en_q <= 1'b0;
		end else if (int_taken) begin
			saved_en_q <= glob_en_q; // RQ12
			glob_en_q <= 1'b0;
		end else if (int_return) begin
			// Return restores the enable saved when the interrupt was taken.
			glob_en_q <= saved_en_q;
		end else if (wr_en & hit_glob) begin
			// Software may load both bits, for instance to unwind nesting.
			glob_en_q <= pwdata[`CISS_GLOB_EN_BIT];
			saved_en_q <= pwdata[`CISS_SAVED_EN_BIT];
		end
	end

	// Sticky status: a routed line sets its bit; writing one clears it.
	// A set in the clearing cycle wins, so no event is lost.
	always @(posedge mclk) begin
		if (sys_rst) begin
			status_q <= 12'h000;
		end else if (wr_en & hit_stat) begin
			status_q <= (status_q & ~pwdata[`CISS_FIRST_PROG +: 12]) | routed;
		end else begin
			status_q <= status_q | routed;
		end
	end

	// Mask register uses the same layout as the status register.
	always @(posedge mclk) begin
		if (sys_rst) begin
			mask_q <= 12'h000;
		end else if (wr_en & hit_mask) begin
			mask_q <= pwdata[`CISS_FIRST_PROG +: 12];
		end
	end

	// Read multiplexer; unused bits read as zero.
	always @* begin
		rdata_d = 32'h00000000;
		if (hit_high) begin
			rdata_d = sel_high_q;
		end else if (hit_low) begin
			rdata_d = sel_low_q;
		end else if (hit_pin) begin
			rdata_d = {24'h000000, gpio_ctrl_q, polarity_q};
		end else if (hit_glob) begin
			rdata_d = {30'h00000000, saved_en_q, glob_en_q};
		end else if (hit_stat) begin
			// Line 4 sits at bit 4, so a bit number is its line number.
			rdata_d = {16'h0000, status_q, 4'h0};
		end else if (hit_mask) begin
			rdata_d = {16'h0000, mask_q, 4'h0};
		end
	end

	// Read data is captured in the setup cycle and held through access.
	always @(posedge mclk) begin
		if (sys_rst) begin
			prdata_q <= 32'h00000000;
		end else if (setup_ph & ~pwrite) begin
			prdata_q <= rdata_d;
		end
	end

	// Core lines: reset and NMI pass ungated, two reserved lines stay low,
	// and the twelve maskable lines are gated by the global enable.
	always @(posedge mclk) begin
		if (sys_rst) begin
			line_q <= 16'h0000;
		end else begin
			// Reset and NMI bypass the enable: the core must always see them.
			line_q[0] <= reset_event; // RQ1
			line_q[1] <= nmi_event; // RQ2
			line_q[3:2] <= 2'h0; // RQ2
			line_q[15:4] <= routed & {12{glob_en_q}}; // RQ12
		end
	end

	assign cpu_int_line = line_q;
	// The core reads both enable bits straight from their flops.
	assign global_enable_bit = glob_en_q;
	assign saved_global_enable_bit = saved_en_q;
	// Level interrupt while any unmasked status bit is set.
	// Masking affects only this output; status still records every event.
	assign irq_out = |(status_q & mask_q);
endmodule // ciss_top

// File: hdl/ciss_map.vh
// Constants for the interrupt source selector: addresses, field layout, resets.
// Assumes it is included by bare name from every design file that needs it.
`ifndef CISS_MAP_VH
`define CISS_MAP_VH

// Byte addresses of the two selector registers.
`define CISS_ADDR_SEL_HIGH 32'h019C0000
`define CISS_ADDR_SEL_LOW 32'h019C0004
// Byte addresses of the support registers beside them.
`define CISS_ADDR_PIN_CTRL 32'h019C0008
`define CISS_ADDR_GLOBAL 32'h019C000C
`define CISS_ADDR_STATUS 32'h019C0010
`define CISS_ADDR_MASK 32'h019C0014

// Reset values of the selector registers.
`define CISS_SEL_LOW_RESET 32'h250718A4
`define CISS_SEL_HIGH_RESET 32'h08202D43
// Bits that belong to one of the six 5-bit fields.
`define CISS_SEL_FIELD_MASK 32'h7FFF7FFF

// Width and low bit of each selector field within its register.
`define CISS_FW 5
`define CISS_F0_LSB 0
`define CISS_F1_LSB 5
`define CISS_F2_LSB 10
`define CISS_F3_LSB 16
`define CISS_F4_LSB 21
`define CISS_F5_LSB 26

// Number of lines, of programmable lines, and of selector codes.
`define CISS_NUM_LINES 16
`define CISS_NUM_PROG 12
`define CISS_FIRST_PROG 4
`define CISS_NUM_CODES 32
// Codes 17 to 21 and 24 to 27 route to no event.
`define CISS_RSVD_CODES 32'h0F3E0000

// Pin control register: polarity in [3:0], module control in [7:4].
`define CISS_POL_LSB 0
`define CISS_GPC_LSB 4
`define CISS_NUM_PINS 4
// Global enable register: enable in bit 0, saved enable in bit 1.
`define CISS_GLOB_EN_BIT 0
`define CISS_SAVED_EN_BIT 1

`endif

// File: hdl/ciss_pin_edge.v
// Edge detector for the four external pins that feed pin events 4 to 7.
// Assumes pin levels are already synchronous to mclk.
`include "ciss_map.vh"

module ciss_pin_edge (
	mclk,
	sys_rst,
	pin_level,
	polarity,
	pin_qualify,
	edge_pulse
);
	input wire mclk;
	input wire sys_rst;
	input wire [3:0] pin_level;
	input wire [3:0] polarity;
	input wire [3:0] pin_qualify;
	output reg [3:0] edge_pulse;

	// Previous level of each pin.
	reg [3:0] last_q;

	genvar i;
	generate
		for (i = 0; i < `CISS_NUM_PINS; i = i + 1) begin : g_pin
			// Polarity 0 picks the rising edge, 1 the falling edge.
			// A pin not enabled as an input never raises an event.
			always @(posedge mclk) begin
				if (sys_rst) begin
					// Start from the present level, so a pin that idles high
					// gives no false edge right after reset.
					last_q[i] <= pin_level[i];
					edge_pulse[i] <= 1'b0;
				end else begin
					last_q[i] <= pin_level[i];
					edge_pulse[i] <= pin_qualify[i] & (polarity[i] ?
						(last_q[i] & ~pin_level[i]) :
						(~last_q[i] & pin_level[i])); // RQ9
				end
			end
		end
	endgenerate
endmodule // ciss_pin_edge

// File: hdl/ciss_route.v
// Per-line event router: each programmable line picks one of 32 events.
// Assumes events are levels or pulses synchronous to mclk.
`include "ciss_map.vh"

module ciss_route (
	mclk,
	sys_rst,
	event_vec,
	sel_flat,
	line_out
);
	input wire mclk;
	input wire sys_rst;
	input wire [31:0] event_vec;
	input wire [59:0] sel_flat;
	output reg [11:0] line_out;

	// Reserved codes are forced off so a stray input can never leak through.
	wire [31:0] legal_vec = event_vec & ~`CISS_RSVD_CODES; // RQ13

	genvar i;
	generate
		for (i = 0; i < `CISS_NUM_PROG; i = i + 1) begin : g_line
			// Each line indexes the event vector with its own field.
			always @(posedge mclk) begin
				if (sys_rst) begin
					line_out[i] <= 1'b0;
				end else begin
					line_out[i] <= legal_vec[sel_flat[i*5 +: 5]]; // RQ3
				end
			end
		end
	endgenerate
endmodule // ciss_route

// File: test/ciss_checker.sv
// Concurrent checks on the ports of the interrupt source selector.
// Assumes it is bound into ciss_top and sees only that module's ports.
`include "ciss_map.vh"
module ciss_checker (
	input wire mclk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire reset_event,
	input wire nmi_event,
	input wire int_taken,
	input wire int_return,
	input wire [15:0] cpu_int_line,
	input wire global_enable_bit,
	input wire saved_global_enable_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Access phase and write access of an APB transfer.
	wire acc = psel && penable;
	wire wr_acc = acc && pwrite;
	// The two selector and four support registers sit on consecutive aligned words.
	wire mapped = paddr >= `CISS_ADDR_SEL_HIGH && paddr <= `CISS_ADDR_MASK && paddr[1:0] == 2'h0;
	wire sel = paddr == `CISS_ADDR_SEL_HIGH || paddr == `CISS_ADDR_SEL_LOW;

	a_spare_lines: assert property (cpu_int_line[3:2] == 2'h0)
		else $error("reserved core lines asserted");
	a_fixed_lines: assert property (!$past(sys_rst) |->
		cpu_int_line[0] == $past(reset_event) && cpu_int_line[1] == $past(nmi_event))
		else $error("fixed lines do not follow their sources");
	a_gate_off: assert property (!global_enable_bit |=> cpu_int_line[15:4] == 12'h000)
		else $error("maskable line high while disabled");
	a_take_save: assert property (int_taken |=>
		!global_enable_bit && saved_global_enable_bit == $past(global_enable_bit))
		else $error("enable not saved when taken");
	a_ret_restore: assert property (int_return && !int_taken |=>
		global_enable_bit == $past(saved_global_enable_bit))
		else $error("enable not restored on return");
	a_enable_cause: assert property (!$past(sys_rst) && $changed(global_enable_bit) |->
		$past(int_taken) || $past(int_return) || $past(wr_acc))
		else $error("enable changed without cause");
	a_err_unmapped: assert property (acc |-> pslverr == !mapped)
		else $error("error response wrong for address");
	a_sel_spare: assert property (acc && !pwrite && sel |->
		(prdata & ~`CISS_SEL_FIELD_MASK) == 32'h0)
		else $error("selector spare bits read nonzero");
endmodule // ciss_checker

bind ciss_top ciss_checker ciss_checker_inst (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr,
	.prdata, .pslverr, .reset_event, .nmi_event, .int_taken, .int_return, .cpu_int_line,
	.global_enable_bit, .saved_global_enable_bit);

// File: test/ciss_partner.sv
// Model of the event sources and of the core that takes interrupts.
// Assumes one clock, mclk, shared with the selector.
`include "ciss_map.vh"
module ciss_partner (
	input wire logic mclk,
	input wire logic fire,
	input wire logic [4:0] code,
	input wire logic take_en,
	input wire logic [15:0] cpu_int_line,
	input wire logic global_enable_bit,
	output logic [31:0] ev,
	output logic [3:0] pin_enable_field,
	output logic [3:0] pin_direction_field,
	output logic int_taken,
	output wire logic int_return
);
	timeunit 1ns;
	timeprecision 1ps;
	// Four cycles of handler time between taking and returning.
	logic [3:0] busy_q = 4'h0;
	// Outputs settle at the first edge, while the selector is still in reset.
	// Pins are enabled and set as inputs before use as sources.
	assign pin_enable_field = 4'hF;
	assign pin_direction_field = 4'h0;
	assign int_return = busy_q[3];
	// Events are levels held while fire is high; the core takes one interrupt at a time.
	always @(posedge mclk) begin
		// A reserved code raises every event, so any leak onto its line shows.
		if (!fire)
			ev <= 32'h0;
		else if (((`CISS_RSVD_CODES >> code) & 32'h1) != 32'h0)
			ev <= 32'hFFFFFFFF;
		else
			ev <= 32'h1 << code;
		int_taken <= take_en && global_enable_bit && |cpu_int_line[15:4] && busy_q == 4'h0
			&& !int_taken;
		busy_q <= {busy_q[2:0], int_taken};
	end
endmodule // ciss_partner

// File: test/tb.sv
// Self-checking bench for the interrupt source selector.
// Assumes the design header is on the include path.
`include "ciss_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0, take_en = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, q;
	logic [3:0] pin_level = 4'h0;
	logic [1:0] fixed_ev = 2'h0;
	logic [4:0] code = 5'h00;
	logic e;
	wire [31:0] prdata, ev;
	wire pready, pslverr, irq_out, int_taken, int_return;
	wire global_enable_bit, saved_global_enable_bit;
	wire [15:0] cpu_int_line;
	wire [3:0] pin_enable_field, pin_direction_field;
	int miscompares = 0, samples_checked = 0;

	initial forever #4 mclk = ~mclk;

	ciss_top ciss_top_inst (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .reset_event(fixed_ev[0]), .nmi_event(fixed_ev[1]),
		.host_port_event(ev[0]), .timer0_event(ev[1]), .timer1_event(ev[2]),
		.external_memory_event(ev[3]), .pin_level, .pin_enable_field, .pin_direction_field,
		.gpio_pin_event(ev[7:4]), .pin_event_0(ev[16]), .dma_completion_event(ev[8]),
		.emulation_event_a(ev[9]), .emulation_receive_event(ev[10]),
		.emulation_transmit_event(ev[11]), .serial0_transmit_event(ev[12]),
		.serial0_receive_event(ev[13]), .serial1_transmit_event(ev[14]),
		.serial1_receive_event(ev[15]), .i2c_controller0_event(ev[22]),
		.i2c_controller1_event(ev[23]), .audio0_transmit_event(ev[28]),
		.audio0_receive_event(ev[29]), .audio1_transmit_event(ev[30]),
		.audio1_receive_event(ev[31]), .int_taken, .int_return, .cpu_int_line,
		.global_enable_bit, .saved_global_enable_bit, .irq_out);

	ciss_partner ciss_partner_inst (.mclk, .fire, .code, .take_en, .cpu_int_line,
		.global_enable_bit, .ev, .pin_enable_field, .pin_direction_field, .int_taken, .int_return);

	// Prints the counts and the verdict, then ends the run.
	task test_done;
		$display("checks %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string s, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", s, x, g);
		end
	endtask

	// One APB transfer; waits for pready without assuming a count.
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		q = prdata;
		e = pslverr;
		if (n >= 40)
			miscompares++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		chk("read data", x, q);
		chk("error flag", {31'h0, xe}, {31'h0, e});
	endtask

	task hold(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Main sequence: registers, fixed lines, routing, interrupt, enable, pins.
	initial begin
		logic x;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(`CISS_ADDR_SEL_HIGH, {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0B, 5'h0A, 5'h03}, 1'b0);
		rd(`CISS_ADDR_SEL_LOW, {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04}, 1'b0);
		apb(1'b1, `CISS_ADDR_SEL_LOW, 32'hFFFFFFFF);
		rd(`CISS_ADDR_SEL_LOW, 32'h7FFF7FFF, 1'b0);
		rd(32'h019C0018, 32'h0, 1'b1);
		fixed_ev <= 2'h3;
		hold(2);
		chk("fixed lines", 32'h3, {30'h0, cpu_int_line[1:0]});
		fixed_ev <= 2'h0;
		apb(1'b1, `CISS_ADDR_GLOBAL, 32'h1);
		// Only line 15 reaches irq_out during the sweep.
		apb(1'b1, `CISS_ADDR_MASK, 32'h8000);
		apb(1'b1, `CISS_ADDR_PIN_CTRL, 32'hF0);
		// Every code on the lowest line; reserved codes must stay silent.
		for (int c = 0; c < 32; c++) begin
			x = !(c inside {[17:21], [24:27]});
			apb(1'b1, `CISS_ADDR_SEL_HIGH, {1'b0, 5'(c), 26'h0});
			code <= 5'(c);
			fire <= 1'b1;
			// Source, routed line and core line each take one edge.
			hold(4);
			chk("line 15", {31'h0, x}, {31'h0, cpu_int_line[15]});
			fire <= 1'b0;
			hold(3);
			chk("irq", {31'h0, x}, {31'h0, irq_out});
			apb(1'b1, `CISS_ADDR_STATUS, 32'hFFF0);
			hold(1);
			chk("irq cleared", 32'h0, {31'h0, irq_out});
		end
		// A masked event stays pending and shows once unmasked.
		apb(1'b1, `CISS_ADDR_MASK, 32'h0);
		fire <= 1'b1;
		hold(3);
		fire <= 1'b0;
		chk("irq masked", 32'h0, {31'h0, irq_out});
		apb(1'b1, `CISS_ADDR_MASK, 32'hFFF0);
		hold(1);
		chk("irq unmasked", 32'h1, {31'h0, irq_out});
		// The core takes the interrupt and returns from it.
		fire <= 1'b1;
		take_en <= 1'b1;
		hold(6);
		chk("enable taken", 32'h1, {30'h0, global_enable_bit, saved_global_enable_bit});
		take_en <= 1'b0;
		fire <= 1'b0;
		hold(6);
		chk("enable returned", 32'h1, {31'h0, global_enable_bit});
		// Pin event 4 on rising, then on falling polarity.
		apb(1'b1, `CISS_ADDR_SEL_LOW, `CISS_SEL_LOW_RESET);
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, `CISS_ADDR_PIN_CTRL, {31'h0, p[0]});
			apb(1'b1, `CISS_ADDR_STATUS, 32'hFFF0);
			pin_level <= 4'h1;
			hold(4);
			rd(`CISS_ADDR_STATUS, {27'h0, !p[0], 4'h0}, 1'b0);
			pin_level <= 4'h0;
			hold(4);
			rd(`CISS_ADDR_STATUS, 32'h10, 1'b0);
		end
		test_done;
	end

	// Cuts a hang short; the tests need some 550 cycles.
	initial begin
		#100000;
		miscompares++;
		test_done;
	end
endmodule // tb
